// >>> common/amv_pkg.sv
// Package for the mixer and volume control register bank
package amv_pkg;
    localparam int AMV_AW   = 7;
    localparam int AMV_DW   = 16;
    localparam int AMV_NREG = 11;

    // Register offsets, 16-bit registers at even addresses
    localparam logic [6:0] AMV_OFS_ID   = 7'h00;
    localparam logic [6:0] AMV_OFS_SPK  = 7'h02;
    localparam logic [6:0] AMV_OFS_HP   = 7'h04;
    localparam logic [6:0] AMV_OFS_AUX  = 7'h06;
    localparam logic [6:0] AMV_OFS_MONO = 7'h08;
    localparam logic [6:0] AMV_OFS_LINE = 7'h0A;
    localparam logic [6:0] AMV_OFS_PB   = 7'h0C;
    localparam logic [6:0] AMV_OFS_MICG = 7'h0E;
    localparam logic [6:0] AMV_OFS_MICR = 7'h10;
    localparam logic [6:0] AMV_OFS_RECG = 7'h12;
    localparam logic [6:0] AMV_OFS_RECS = 7'h14;
    localparam logic [6:0] AMV_OFS_BEEP = 7'h16;

    // Capability flags: headphone, no sim stereo, tone, no modem, no mic ADC
    localparam logic [4:0] AMV_ID_FLAGS = 5'h14;

    // Reset values
    localparam logic [15:0] AMV_RST_OUT  = 16'h8080;
    localparam logic [15:0] AMV_RST_MONO = 16'hC880;
    localparam logic [15:0] AMV_RST_PATH = 16'hE808;
    localparam logic [15:0] AMV_RST_MICG = 16'h0808;
    localparam logic [15:0] AMV_RST_MICR = 16'h00DA;
    localparam logic [15:0] AMV_RST_RECG = 16'h8000;
    localparam logic [15:0] AMV_RST_RECS = 16'hD600;
    localparam logic [15:0] AMV_RST_BEEP = 16'hAA00;

    // Implemented-bit masks; all other bits read zero
    localparam logic [15:0] AMV_MSK_FULL = 16'hFFFF;
    localparam logic [15:0] AMV_MSK_MONO = 16'hDFFF;
    localparam logic [15:0] AMV_MSK_PATH = 16'hFF1F;
    localparam logic [15:0] AMV_MSK_MICG = 16'h1F1F;
    localparam logic [15:0] AMV_MSK_MICR = 16'h00FF;
    localparam logic [15:0] AMV_MSK_RECS = 16'hFF7F;
    localparam logic [15:0] AMV_MSK_BEEP = 16'hFF00;

    // Output volume code clamp: any code with top bit set is the floor
    localparam logic [5:0] AMV_LVL_FLOOR = 6'h1F;

    // Index 0 is 02h, index 10 is 16h
    localparam logic [AMV_NREG-1:0][15:0] AMV_RST_ALL = {
        AMV_RST_BEEP, AMV_RST_RECS, AMV_RST_RECG, AMV_RST_MICR, AMV_RST_MICG,
        AMV_RST_PATH, AMV_RST_PATH, AMV_RST_MONO, AMV_RST_OUT, AMV_RST_OUT,
        AMV_RST_OUT};
    localparam logic [AMV_NREG-1:0][15:0] AMV_MSK_ALL = {
        AMV_MSK_BEEP, AMV_MSK_RECS, AMV_MSK_FULL, AMV_MSK_MICR, AMV_MSK_MICG,
        AMV_MSK_PATH, AMV_MSK_PATH, AMV_MSK_MONO, AMV_MSK_FULL, AMV_MSK_FULL,
        AMV_MSK_FULL};

    typedef struct packed {
        logic       silence;
        logic       zero_cross;
        logic [5:0] level;
    } amv_out_t;

    typedef struct packed {
        amv_out_t left_out;
        amv_out_t right_out;
    } amv_pair_t;

    typedef struct packed {
        logic       monoinput_to_headphone_silence;
        logic       monoinput_to_speaker_silence;
        logic       rsv;
        logic [4:0] single_input_gain;
        amv_out_t   single_out;
    } amv_mono_t;

    typedef struct packed {
        logic       to_headphone_silence;
        logic       to_speaker_silence;
        logic       to_single_silence;
        logic [4:0] left_gain;
        logic [2:0] rsv;
        logic [4:0] right_gain;
    } amv_path_t;

    typedef struct packed {
        logic [2:0] rsv_hi;
        logic [4:0] first_mic_gain;
        logic [2:0] rsv_lo;
        logic [4:0] second_mic_gain;
    } amv_micg_t;

    typedef struct packed {
        logic [7:0] rsv;
        logic       first_mic_to_single_silence;
        logic       second_mic_to_single_silence;
        logic       mic_single_boost;
        logic [1:0] mic_headphone_path_select;
        logic [2:0] mic_headphone_path_level;
    } amv_micr_t;

    typedef struct packed {
        logic       record_input_silence;
        logic       left_record_range;
        logic [5:0] left_record_level;
        logic       zero_crossing_enable;
        logic       right_record_range;
        logic [5:0] right_record_level;
    } amv_recg_t;

    typedef struct packed {
        logic [1:0] record_to_headphone_select;
        logic [2:0] record_to_headphone_level;
        logic [1:0] record_to_single_select;
        logic       record_path_boost;
        logic       rsv;
        logic       record_boost;
        logic [2:0] left_record_source;
        logic [2:0] right_record_source;
    } amv_recs_t;

    typedef struct packed {
        logic       beep_to_headphone_silence;
        logic [2:0] beep_to_headphone_level;
        logic       beep_to_speaker_silence;
        logic [2:0] beep_to_speaker_level;
        logic [7:0] rsv;
    } amv_beep_t;

    // Field view of the bank, highest register first to match word order
    typedef struct packed {
        amv_beep_t beep;
        amv_recs_t rec_sel;
        amv_recg_t rec_gain;
        amv_micr_t mic_route;
        amv_micg_t mic_gain;
        amv_path_t playback;
        amv_path_t line;
        amv_mono_t mono;
        amv_pair_t aux;
        amv_pair_t headphone;
        amv_pair_t speaker;
    } amv_ctrl_t;

    typedef struct packed {
        logic [AMV_NREG-1:0][15:0] word;
        logic [15:0]               rdata;
        logic                      rvalid;
    } amv_state_t;
endpackage : amv_pkg

// >>> design/amv_regs.sv
// Mixer, volume and record gain control register bank
`timescale 1ns/1ns

module amv_regs
    import amv_pkg::*;
#(
    parameter logic [10:0] P_ID_UPPER = 11'h000  // Arbitrary upper ID value
)
(
    input  wire logic              I_REF_CLK,
    input  wire logic              I_SRST,
    input  wire logic              I_WR_EN,
    input  wire logic              I_RD_EN,
    input  wire logic [AMV_AW-1:0] I_ADDR,
    input  wire logic [AMV_DW-1:0] I_WDATA,
    output logic      [AMV_DW-1:0] O_RDATA,
    output logic                   O_RD_VALID,
    output amv_ctrl_t              O_CTRL
);

    amv_state_t  st_r;
    amv_state_t  st_nxt;
    logic        hit;
    logic [3:0]  idx;
    logic [15:0] rd_word;
    amv_ctrl_t   raw;

    // Clamp an output attenuation code; codes 1xxxxx act as the floor
    function automatic logic [5:0] sat_level(input logic [5:0] code);
        sat_level = code[5] ? AMV_LVL_FLOOR : code;
    endfunction : sat_level

    // Standard record range ignores the top two level bits
    function automatic logic [5:0] rec_level(input logic ext, input logic [5:0] code);
        rec_level = ext ? code : {2'h0, code[3:0]};
    endfunction : rec_level

    // Address decode: even offsets 02h..16h map to word 0..10
    always_comb
    begin
        hit = (I_ADDR[0] == 1'b0) && (I_ADDR[6:5] == 2'h0)
              && (I_ADDR[4:1] != 4'h0) && (I_ADDR[4:1] <= 4'hB);
        idx = I_ADDR[4:1] - 4'h1;
    end

    // Read mux; odd or unmapped addresses answer zero
    always_comb
    begin
        if (I_ADDR == AMV_OFS_ID)
        begin
            rd_word = {P_ID_UPPER, AMV_ID_FLAGS};
        end
        else if (hit)
        begin
            rd_word = st_r.word[idx];
        end
        else
        begin
            rd_word = 16'h0000;
        end
    end

    // Next state: read capture and masked writes
    always_comb
    begin
        st_nxt        = st_r;
        st_nxt.rvalid = 1'b0;
        if (I_RD_EN)
        begin
            // A read in a write cycle sees the value before the write
            st_nxt.rvalid = 1'b1;
            st_nxt.rdata  = rd_word;
        end
        if (I_WR_EN)
        begin
            if (I_ADDR == AMV_OFS_ID)
            begin
                st_nxt.word = AMV_RST_ALL;
            end
            else if (hit)
            begin
                // Mask keeps unassigned bits at zero
                st_nxt.word[idx] = I_WDATA & AMV_MSK_ALL[idx];
            end
        end
    end

    // State register; defaults give muted outputs and 0dB gains
    always_ff @(posedge I_REF_CLK)
    begin
        if (I_SRST)
        begin
            st_r <= '{word: AMV_RST_ALL, rdata: 16'h0000, rvalid: 1'b0};
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    assign O_RDATA    = st_r.rdata;
    assign O_RD_VALID = st_r.rvalid;

    // Field view of the stored words
    assign raw = amv_ctrl_t'(st_r.word);

    // Effective settings for the analogue side: levels clamped so the
    // mixers never see an out-of-range code; readback stays raw.
    always_comb
    begin
        O_CTRL = raw;
        O_CTRL.speaker.left_out.level    = sat_level(raw.speaker.left_out.level);
        O_CTRL.speaker.right_out.level   = sat_level(raw.speaker.right_out.level);
        O_CTRL.headphone.left_out.level  = sat_level(raw.headphone.left_out.level);
        O_CTRL.headphone.right_out.level = sat_level(raw.headphone.right_out.level);
        O_CTRL.aux.left_out.level        = sat_level(raw.aux.left_out.level);
        O_CTRL.aux.right_out.level       = sat_level(raw.aux.right_out.level);
        O_CTRL.mono.single_out.level     = sat_level(raw.mono.single_out.level);
        O_CTRL.rec_gain.left_record_level =
            rec_level(raw.rec_gain.left_record_range,
                      raw.rec_gain.left_record_level);
        O_CTRL.rec_gain.right_record_level =
            rec_level(raw.rec_gain.right_record_range,
                      raw.rec_gain.right_record_level);
    end

endmodule : amv_regs

// >>> tb/amv_regs_props.sv
// Assertion checker for the mixer volume register bank
`timescale 1ns/1ns
module amv_regs_props
    import amv_pkg::*;
#(
    parameter logic [10:0] P_ID_UPPER = 11'h000
)
(
    input wire logic              I_REF_CLK,
    input wire logic              I_SRST,
    input wire logic              I_WR_EN,
    input wire logic              I_RD_EN,
    input wire logic [AMV_AW-1:0] I_ADDR,
    input wire logic [AMV_DW-1:0] I_WDATA,
    input wire logic [AMV_DW-1:0] O_RDATA,
    input wire logic              O_RD_VALID,
    input wire amv_ctrl_t         O_CTRL
);
    default clocking cb @(posedge I_REF_CLK); endclocking
    default disable iff (I_SRST);
    // Request kinds, the step before each answer
    sequence s_rd(a); I_RD_EN && I_ADDR == a; endsequence
    sequence s_wr(a); I_WR_EN && I_ADDR == a; endsequence
    property p_rd_v; I_RD_EN |=> O_RD_VALID; endproperty
    a_rd_v: assert property (p_rd_v) else $error("read not answered");
    property p_rd_idle; !I_RD_EN |=> !O_RD_VALID && $stable(O_RDATA); endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("stray read data");
    property p_id; s_rd(AMV_OFS_ID) |=> O_RDATA == {P_ID_UPPER, 5'h14}; endproperty
    a_id: assert property (p_id) else $error("id word wrong");
    property p_dflt; s_wr(AMV_OFS_ID) |=> O_CTRL == amv_ctrl_t'(AMV_RST_ALL); endproperty
    a_dflt: assert property (p_dflt) else $error("id write no default");
    property p_unmap; I_RD_EN && (I_ADDR[0] || I_ADDR > 7'h16) |=> O_RDATA == 16'h0000;
    endproperty
    a_unmap: assert property (p_unmap) else $error("unmapped read nonzero");
    property p_spk;
        s_wr(AMV_OFS_SPK) |=> O_CTRL.speaker.right_out.silence == $past(I_WDATA[7]);
    endproperty
    a_spk: assert property (p_spk) else $error("speaker mute wrong");
    property p_clamp;
        s_wr(AMV_OFS_SPK) ##0 I_WDATA[13] |=> O_CTRL.speaker.left_out.level == 6'h1F;
    endproperty
    a_clamp: assert property (p_clamp) else $error("level not clamped");
    property p_rec;
        !O_CTRL.rec_gain.left_record_range |-> O_CTRL.rec_gain.left_record_level[5:4] == 2'b00;
    endproperty
    a_rec: assert property (p_rec) else $error("record range leak");
endmodule : amv_regs_props

bind amv_regs amv_regs_props #(.P_ID_UPPER(P_ID_UPPER)) u_props (
    .I_REF_CLK(I_REF_CLK), .I_SRST(I_SRST), .I_WR_EN(I_WR_EN), .I_RD_EN(I_RD_EN),
    .I_ADDR(I_ADDR), .I_WDATA(I_WDATA), .O_RDATA(O_RDATA), .O_RD_VALID(O_RD_VALID),
    .O_CTRL(O_CTRL));

// >>> tb/amv_host.sv
// Host link controller model driving register strobes
`timescale 1ns/1ns
module amv_host
    import amv_pkg::*;
(
    input  wire logic              i_clk,
    output logic                   o_wr_en,
    output logic                   o_rd_en,
    output logic      [AMV_AW-1:0] o_addr,
    output logic      [AMV_DW-1:0] o_wdata
);
    // Quiet bus from time zero
    initial {o_wr_en, o_rd_en, o_addr, o_wdata} = '0;
    // One request per falling edge, taken at the next rising edge
    task automatic op(input logic w, input logic r, input logic [6:0] a, input logic [15:0] d);
        @(negedge i_clk);
        {o_wr_en, o_rd_en, o_addr, o_wdata} = {w, r, a, d};
    endtask : op
    // Released lines flip so a stale value never looks valid
    task automatic idle();
        op(1'b0, 1'b0, ~o_addr, ~o_wdata);
    endtask : idle
endmodule : amv_host

// >>> tb/amv_regs_tb.sv
// Self-checking testbench for the mixer volume register bank
`timescale 1ns/1ns
module amv_regs_tb import amv_pkg::*;;
    localparam logic [10:0] P_ID = 11'h2A5;  // Arbitrary ID value
    logic              clk, srst, wr, rd, rv;
    logic [AMV_AW-1:0] a;
    logic [AMV_DW-1:0] wd, rdat, d;
    amv_ctrl_t         ctrl;
    int                error_cnt, checked;
    amv_regs #(.P_ID_UPPER(P_ID)) DUT (.I_REF_CLK(clk), .I_SRST(srst), .I_WR_EN(wr),
        .I_RD_EN(rd), .I_ADDR(a), .I_WDATA(wd), .O_RDATA(rdat), .O_RD_VALID(rv),
        .O_CTRL(ctrl));
    amv_host h (.i_clk(clk), .o_wr_en(wr), .o_rd_en(rd), .o_addr(a), .o_wdata(wd));
    // 50 MHz clock
    initial
    begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    task automatic complete_run();
        if (error_cnt == 0 && checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : complete_run
    task automatic cmp(input string n, input logic [15:0] s, input logic [15:0] e);
        checked++;
        if (s !== e)
        begin
            error_cnt++;
            $display("mismatch %s expected %h seen %h", n, e, s);
        end
    endtask : cmp
    // Read answer lands one edge later and stands one cycle
    task automatic rdc(input logic [6:0] ad, input logic [15:0] e);
        h.op(1'b0, 1'b1, ad, 16'h0000);
        h.idle();
        cmp("valid", 16'(rv), 16'h0001);
        cmp("rdata", rdat, e);
    endtask : rdc
    task automatic dflt();
        for (int i = 0; i < AMV_NREG; i++)
            rdc(7'(2 * i + 2), AMV_RST_ALL[i]);
        cmp("ctrl", ctrl[15:0], 16'h8080);
        cmp("mono_gain", 16'(ctrl.mono.single_input_gain), 16'h0008);
        cmp("mic_path", 16'(ctrl.mic_route.mic_headphone_path_select), 16'h0003);
        cmp("beep_lvl", 16'(ctrl.beep.beep_to_speaker_level), 16'h0002);
    endtask : dflt
    // Expected control view: clamped levels, range-limited record codes
    function automatic logic [5:0] clmp(input logic [5:0] c);
        return c[5] ? 6'h1F : c;
    endfunction : clmp
    function automatic logic [5:0] rlv(input logic g, input logic [5:0] c);
        return g ? c : {2'b00, c[3:0]};
    endfunction : rlv
    // Hang guard
    initial
    begin
        #1000000;
        error_cnt++;
        complete_run();
    end
    initial
    begin
        error_cnt = 0;
        checked = 0;
        srst = 1'b1;
        void'($urandom(32'h524f));
        repeat (16) @(negedge clk);
        srst = 1'b0;
        dflt();
        rdc(AMV_OFS_ID, {P_ID, 5'h14});
        // Back-to-back writes, read in the write cycle sees the old word
        for (int i = 0; i < AMV_NREG; i++)
        begin
            d = 16'($urandom);
            h.op(1'b1, 1'b0, 7'(2 * i + 2), d);
            h.op(1'b1, 1'b1, 7'(2 * i + 2), ~d);
            h.idle();
            cmp("old", rdat, d & AMV_MSK_ALL[i]);
            rdc(7'(2 * i + 2), ~d & AMV_MSK_ALL[i]);
        end
        // All-ones corner first, then random codes
        for (int k = 0; k < 6; k++)
        begin
            d = (k == 0) ? 16'hFFFF : 16'($urandom);
            h.op(1'b1, 1'b0, AMV_OFS_SPK, d);
            h.op(1'b1, 1'b0, AMV_OFS_RECG, d);
            h.idle();
            cmp("spk_lvl", 16'(ctrl.speaker.left_out.level), 16'(clmp(d[13:8])));
            cmp("rec_lvl", 16'(ctrl.rec_gain.right_record_level), 16'(rlv(d[6], d[5:0])));
        end
        h.op(1'b1, 1'b0, 7'h03, 16'hFFFF);
        h.op(1'b1, 1'b0, 7'h7E, 16'h0000);
        rdc(7'h18, 16'h0000);
        rdc(7'h03, 16'h0000);
        rdc(AMV_OFS_SPK, d);
        // All-ones words show exactly which bits each layout keeps
        h.op(1'b1, 1'b0, AMV_OFS_LINE, 16'hFFFF);
        h.op(1'b1, 1'b0, AMV_OFS_MONO, 16'hFFFF);
        rdc(AMV_OFS_LINE, 16'hFF1F);
        rdc(AMV_OFS_MONO, 16'hDFFF);
        h.op(1'b1, 1'b0, AMV_OFS_ID, 16'($urandom));
        h.idle();
        dflt();
        rdc(AMV_OFS_ID, {P_ID, 5'h14});
        // Second reset in mid-run
        h.op(1'b1, 1'b0, AMV_OFS_HP, 16'h0000);
        h.idle();
        srst = 1'b1;
        repeat (2) @(negedge clk);
        srst = 1'b0;
        dflt();
        complete_run();
    end
endmodule : amv_regs_tb
